/* hdl/rco_defines.svh */
`ifndef RCO_DEFINES_SVH
`define RCO_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses on the Avalon-MM slave).
// ****************************************************************
`define RCO_CTRL_OFFSET     4'h0
`define RCO_AUX_OFFSET      4'h4

// ****************************************************************
// Field positions of the reference clock control register.
// ****************************************************************
`define RCO_ENABLE_BIT      15
`define RCO_SLEEP_RUN_BIT   13
`define RCO_SOURCE_BIT      12
`define RCO_DIV_MSB         11
`define RCO_DIV_LSB         8
`define RCO_CTRL_MASK       16'hBF00
`define RCO_CTRL_HI_MASK    8'hBF

// ****************************************************************
// Field positions of the auxiliary oscillator register.
// ****************************************************************
`define RCO_KEEP_ALIVE_BIT  0
`define RCO_RUNNING_BIT     8
`define RCO_POSC_OFF_BIT    9

// ****************************************************************
// Reset values.
// ****************************************************************
`define RCO_CTRL_RESET      16'h0000
`define RCO_KEEP_RESET      1'b0

`endif

/* hdl/rco_div_if.sv */
`timescale 1ns/1ps

// ****************************************************************
// Signals between the control logic and the divider.
// ****************************************************************
interface rco_div_if;
  import rco_pkg::*;

  logic     tick;       // One-cycle pulse on a base clock rising edge.
  logic     base_level; // Synchronised level of the selected base clock.
  logic     run;        // Divider may run; low holds it cleared.
  rco_div_t divisor;    // Requested divisor code.
  logic     clk_out;    // Divided clock, registered.

  modport ctrl (output tick, output base_level, output run,
                output divisor, input clk_out);
  modport div  (input tick, input base_level, input run,
                input divisor, output clk_out);
endinterface : rco_div_if

/* hdl/rco_divider.sv */
`timescale 1ns/1ps

// ****************************************************************
// Power-of-two divider with glitch-free divisor changes.
// ****************************************************************
module rco_divider
  import rco_pkg::*;
(
  input  wire logic i_mclk,  // System clock.
  input  wire logic i_rstn,  // Asynchronous reset, active low.
  rco_div_if.div    bus      // Divider control and output.
);

  rco_count_t cnt_reg;
  rco_count_t cnt_next;
  logic       out_reg;
  logic       out_next;
  rco_div_t   act_reg;
  rco_div_t   act_next;
  rco_count_t half_last;

  // Last count of a half period: 2**(n-1) base edges, minus one.
  always_comb
  begin
    half_last = 15'h0000;
    if (act_reg != 4'h0)
    begin
      half_last = rco_count_t'((16'h0001 << (act_reg - 4'h1)) - 16'h0001);
    end
  end

  // Next state: count base edges, toggle each half period and take a
  // new divisor only while the output is low.
  always_comb
  begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    act_next = act_reg;
    if (!bus.run)
    begin
      cnt_next = 15'h0000;
      out_next = 1'b0;
      act_next = bus.divisor;
    end
    else if (act_reg == 4'h0)
    begin
      // A pending divisor keeps the output low so no runt high starts.
      if (out_reg || bus.divisor == act_reg)
      begin
        out_next = bus.base_level;
      end
      if (!out_reg && !bus.base_level)
      begin
        act_next = bus.divisor;
      end
    end
    else if (bus.tick)
    begin
      if (cnt_reg == half_last)
      begin
        cnt_next = 15'h0000;
        out_next = !out_reg;
        if (out_reg)
        begin
          act_next = bus.divisor;
        end
      end
      else
      begin
        cnt_next = cnt_reg + 15'h0001;
      end
    end
  end

  // State registers.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_reg <= 15'h0000;
      out_reg <= 1'b0;
      act_reg <= 4'h0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      act_reg <= act_next;
    end
  end

  assign bus.clk_out = out_reg;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_stop_clears: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    !bus.run |=> (cnt_reg == 15'h0000) && !out_reg)
    else $error("Divider not cleared while stopped.");

  a_half_toggle: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (bus.run && act_reg != 4'h0 && bus.tick && cnt_reg == half_last)
    |=> out_reg != $past(out_reg))
    else $error("Divided output missed its half-period toggle.");

  a_no_short_pulse: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (bus.run && $past(bus.run) && act_reg != 4'h0 && !bus.tick
     && $past(act_reg) != 4'h0) |=> out_reg == $past(out_reg))
    else $error("Divided output changed without a base edge.");

  a_div_hold_high: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (bus.run && out_next) |=> act_reg == $past(act_reg))
    else $error("Divisor changed while the output was high.");

endmodule : rco_divider

/* hdl/rco_pkg.sv */
// ****************************************************************
// Types shared by the reference clock output design.
// ****************************************************************
package rco_pkg;

  // Divisor code: 0 passes the base clock, n divides by 2**n.
  typedef logic [3:0]  rco_div_t;
  // Half-period counter of the divider.
  typedef logic [14:0] rco_count_t;
  // Avalon-MM data word.
  typedef logic [31:0] rco_word_t;
  // Control register contents.
  typedef logic [15:0] rco_ctrl_t;

endpackage : rco_pkg

/* hdl/rco_top.sv */
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "rco_defines.svh"

// Operation
// - Enable bit drives divided clock onto pin.
// - Divisor code n divides base by two-power-n.
// - Source bit one selects primary oscillator.
// - Source bit zero selects current system clock.
// - Run-in-sleep bit keeps output running asleep.
// - Sleep running needs run-in-sleep and source set.
// - Sleep powers primary down unless mode/keep-alive.
// - Bit 14 and bits 7-0 read zero.
// - Implemented bits read/write, reset to zero.
// - Works under every oscillator configuration.
module rco_top
  import rco_pkg::*;
(
  input  wire logic             i_mclk,        // 25 MHz clock.
  input  wire logic             i_rstn,        // Async reset, low.
  input  wire logic [3:0]       i_address,     // Avalon byte address.
  input  wire logic             i_read,        // Avalon read.
  input  wire logic             i_write,       // Avalon write.
  input  wire logic [3:0]       i_byteenable,  // Avalon byte enables.
  input  wire rco_pkg::rco_word_t i_writedata, // Avalon write data.
  output logic                  o_waitrequest, // Avalon wait.
  output rco_pkg::rco_word_t    o_readdata,    // Avalon read data.
  input  wire logic             i_posc_clk,    // Primary oscillator.
  input  wire logic             i_sys_clk,     // Current system clock.
  input  wire logic             i_sleep,       // Device in Sleep.
  input  wire logic             i_posc_mode,   // Primary mode config.
  input  wire logic             i_posc_on,     // Primary osc powered.
  output logic                  o_posc_pwrdn,  // Primary osc off req.
  output logic                  o_refout_pin   // Reference clock pin.
);
  import rco_pkg::*;

  rco_div_if div_bus ();

  // ****************************************************************
  // Register bus slave.
  // ****************************************************************
  // Software registers and the bus answer.
  rco_ctrl_t ctrl_reg;
  rco_ctrl_t ctrl_next;
  logic      keep_reg;
  logic      keep_next;
  logic      wait_reg;
  logic      wait_next;
  rco_word_t rdata_reg;
  rco_word_t rdata_next;
  logic      wr_take;
  logic      refout_enable;
  logic      refout_run_in_sleep;
  logic      refout_source_select;
  rco_div_t  refout_divisor;

  // Decoded fields of the control register.
  assign refout_enable        = ctrl_reg[`RCO_ENABLE_BIT];
  assign refout_run_in_sleep  = ctrl_reg[`RCO_SLEEP_RUN_BIT];
  assign refout_source_select = ctrl_reg[`RCO_SOURCE_BIT];
  assign refout_divisor       = ctrl_reg[`RCO_DIV_MSB:`RCO_DIV_LSB];

  // A write takes effect at the edge where waitrequest is sampled low.
  assign wr_take = i_write && !wait_reg;

  // Next values of the bus answer and the software registers.
  always_comb
  begin
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    ctrl_next  = ctrl_reg;
    keep_next  = keep_reg;
    if ((i_read || i_write) && wait_reg)
    begin
      wait_next  = 1'b0;
      rdata_next = 32'h0000_0000;
      if (i_read && i_address == `RCO_CTRL_OFFSET)
      begin
        rdata_next[15:0] = ctrl_reg & `RCO_CTRL_MASK;
      end
      else if (i_read && i_address == `RCO_AUX_OFFSET)
      begin
        rdata_next[`RCO_KEEP_ALIVE_BIT] = keep_reg;
        rdata_next[`RCO_RUNNING_BIT]    = div_bus.run;
        rdata_next[`RCO_POSC_OFF_BIT]   = o_posc_pwrdn;
      end
    end
    if (wr_take && i_address == `RCO_CTRL_OFFSET && i_byteenable[1])
    begin
      ctrl_next[15:8] = i_writedata[15:8] & `RCO_CTRL_HI_MASK;
    end
    if (wr_take && i_address == `RCO_AUX_OFFSET && i_byteenable[0])
    begin
      keep_next = i_writedata[`RCO_KEEP_ALIVE_BIT];
    end
  end

  // Bus and register flip-flops; all implemented bits clear at reset.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_reg  <= `RCO_CTRL_RESET;
      keep_reg  <= `RCO_KEEP_RESET;
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      keep_reg  <= keep_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_waitrequest = wait_reg;
  assign o_readdata    = rdata_reg;

  // ****************************************************************
  // Base clock synchronisers and edge detection.
  // ****************************************************************
  // Synchroniser chains and the chosen base clock.
  logic [1:0] posc_sync_reg;
  logic [1:0] sys_sync_reg;
  logic       posc_last_reg;
  logic       sys_last_reg;
  logic       src_reg;
  logic       src_next;
  logic       posc_tick;
  logic       sys_tick;
  logic       src_pend;

  // Two flip-flops per clock pin, then one more for edge detection.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      posc_sync_reg <= 2'h0;
      sys_sync_reg  <= 2'h0;
      posc_last_reg <= 1'b0;
      sys_last_reg  <= 1'b0;
    end
    else
    begin
      posc_sync_reg <= {posc_sync_reg[0], i_posc_clk};
      sys_sync_reg  <= {sys_sync_reg[0], i_sys_clk};
      posc_last_reg <= posc_sync_reg[1];
      sys_last_reg  <= sys_sync_reg[1];
    end
  end

  assign posc_tick = posc_sync_reg[1] && !posc_last_reg;
  assign sys_tick  = sys_sync_reg[1] && !sys_last_reg;

  // A source change is taken while the output is low; for that cycle the
  // divider sees no edge and a low base, so no runt pulse can start.
  assign src_pend = (src_reg != refout_source_select) && !div_bus.clk_out;

  // The source follows the register only while the output is low.
  always_comb
  begin
    src_next = src_reg;
    if (!div_bus.clk_out)
    begin
      src_next = refout_source_select;
    end
  end

  // ****************************************************************
  // Sleep, oscillator power and divider control.
  // ****************************************************************
  logic pwrdn_next;
  logic pin_next;

  // Primary oscillator stays up in Sleep only by mode or keep-alive.
  assign pwrdn_next = i_sleep && !(i_posc_mode || keep_reg);

  // Divider runs under any oscillator mode; in Sleep only from a live
  // primary oscillator with sleep running requested.
  always_comb
  begin
    div_bus.run = refout_enable &&
                  (!i_sleep ||
                   (refout_run_in_sleep && refout_source_select
                    && src_reg && i_posc_on && !pwrdn_next));
    div_bus.tick       = src_pend ? 1'b0
                       : (src_reg ? posc_tick : sys_tick);
    div_bus.base_level = src_pend ? 1'b0
                       : (src_reg ? posc_sync_reg[1]
                                  : sys_sync_reg[1]);
    div_bus.divisor    = refout_divisor;
    pin_next           = div_bus.clk_out && div_bus.run;
  end

  // Output and source flip-flops.
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      src_reg      <= 1'b0;
      o_posc_pwrdn <= 1'b0;
      o_refout_pin <= 1'b0;
    end
    else
    begin
      src_reg      <= src_next;
      o_posc_pwrdn <= pwrdn_next;
      o_refout_pin <= pin_next;
    end
  end

  // Divider driven through the shared interface.
  rco_divider u_divider (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .bus    (div_bus)
  );

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_pin_off_disabled: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    !refout_enable |=> !o_refout_pin)
    else $error("Reference pin active while disabled.");

  a_reserved_zero: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    !o_waitrequest |-> (o_readdata[31:16] == 16'h0000)
                       && (o_readdata[14] == 1'b0)
                       && (o_readdata[7:0] == 8'h00 ||
                           $past(i_address) == `RCO_AUX_OFFSET))
    else $error("Unimplemented bits read nonzero.");

  a_ctrl_write: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (wr_take && i_address == `RCO_CTRL_OFFSET && i_byteenable[1])
    |=> ctrl_reg[15:8] == ($past(i_writedata[15:8]) & 8'hBF))
    else $error("Control write not stored.");

  a_sleep_stop: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_sleep && !(refout_run_in_sleep && refout_source_select))
    |=> !o_refout_pin)
    else $error("Reference pin ran in Sleep without both bits.");

  a_posc_pwrdn: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_sleep && !i_posc_mode && !keep_reg) |=> o_posc_pwrdn)
    else $error("Primary oscillator not powered down in Sleep.");

  a_src_system: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (!src_reg && !refout_source_select && sys_sync_reg[1]
     && !$past(sys_sync_reg[1])) |-> div_bus.tick)
    else $error("System clock edge not passed to divider.");

  a_src_primary: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (src_reg && refout_source_select && posc_sync_reg[1]
     && !$past(posc_sync_reg[1])) |-> div_bus.tick)
    else $error("Primary clock edge not passed to divider.");

  a_src_pending: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (src_reg != refout_source_select && !div_bus.clk_out)
    |=> !div_bus.clk_out && src_reg == $past(refout_source_select))
    else $error("Source change not taken while the output was low.");

  a_pin_follows: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    div_bus.run |=> o_refout_pin == $past(div_bus.clk_out))
    else $error("Reference pin does not follow the divider.");

  a_posc_kept: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_posc_mode || keep_reg) |=> !o_posc_pwrdn)
    else $error("Primary oscillator powered down while kept alive.");

  a_sleep_posc_off: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_sleep && !i_posc_on) |=> !o_refout_pin)
    else $error("Reference pin ran in Sleep from a stopped oscillator.");

  a_aux_keep: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (wr_take && i_address == `RCO_AUX_OFFSET && i_byteenable[0])
    |=> keep_reg == $past(i_writedata[`RCO_KEEP_ALIVE_BIT]))
    else $error("Keep-alive write not stored.");

  a_unmapped_read: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_read && o_waitrequest && i_address != `RCO_CTRL_OFFSET
     && i_address != `RCO_AUX_OFFSET) |=> o_readdata == 32'h0000_0000)
    else $error("Unmapped read returned nonzero data.");

  a_ctrl_readback: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_read && o_waitrequest && i_address == `RCO_CTRL_OFFSET)
    |=> o_readdata == {16'h0000, $past(ctrl_reg) & `RCO_CTRL_MASK})
    else $error("Control read returned the wrong value.");

  a_bus_answer: assert property (
    @(posedge i_mclk) disable iff (!i_rstn)
    ((i_read || i_write) && o_waitrequest) |=> !o_waitrequest)
    else $error("Bus request not answered in one cycle.");

endmodule : rco_top

/* test/rco_refout_monitor.sv */
`timescale 1ns/1ps

// ****************************************************************
// External device that samples the reference pin on the system clock; it times each level.
// ****************************************************************
module rco_refout_monitor
(
  input  wire logic        i_mclk,   // Sampling clock.
  input  wire logic        i_pin,    // Reference clock pin.
  output logic [31:0]      o_hi_len, // Last high time in cycles.
  output logic [31:0]      o_lo_len, // Last low time in cycles.
  output logic [31:0]      o_edges   // Pin edges seen so far.
);
  logic        last_reg  = 1'b0;
  logic [31:0] cnt_reg   = 32'h0000_0000;
  logic [31:0] hi_reg    = 32'h0000_0000;
  logic [31:0] lo_reg    = 32'h0000_0000;
  logic [31:0] edges_reg = 32'h0000_0000;

  // Measured lengths and the edge count, one driver each.
  assign o_hi_len = hi_reg;
  assign o_lo_len = lo_reg;
  assign o_edges  = edges_reg;

  // Counts samples at each level and stores the count when it ends.
  always @(posedge i_mclk)
  begin
    if (i_pin !== last_reg)
    begin
      if (last_reg)
        hi_reg <= cnt_reg;
      else
        lo_reg <= cnt_reg;
      edges_reg <= edges_reg + 32'h0000_0001;
      cnt_reg <= 32'h0000_0001;
    end
    else
      cnt_reg <= cnt_reg + 32'h0000_0001;
    last_reg <= i_pin;
  end
endmodule : rco_refout_monitor

/* test/testbench.sv */
`timescale 1ns/1ps

// ****************************************************************
// Self-checking bench for the reference clock output.
// ****************************************************************
module testbench;
  import rco_pkg::*;

  logic        i_mclk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [3:0]  i_address = 4'h0;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [3:0]  i_byteenable = 4'hF;
  rco_word_t   i_writedata = 32'h0000_0000;
  logic        o_waitrequest;
  rco_word_t   o_readdata;
  logic        i_posc_clk = 1'b0;
  logic        i_sys_clk = 1'b0;
  logic        i_sleep = 1'b0;
  logic        i_posc_mode = 1'b0;
  logic        i_posc_on = 1'b1;
  logic        o_posc_pwrdn;
  logic        o_refout_pin;
  logic [31:0] hi_len;
  logic [31:0] lo_len;
  logic [31:0] edges;
  int          failures = 0;
  int          samples_checked = 0;
  int          sys_cnt = 0;
  int          posc_cnt = 0;
  rco_word_t   rd;

  // The 25 MHz clock.
  always #20 i_mclk = ~i_mclk;

  // Base clocks: system period 8 cycles, primary period 12 cycles.
  always @(posedge i_mclk)
  begin
    sys_cnt <= (sys_cnt + 1) % 4;
    posc_cnt <= (posc_cnt + 1) % 6;
    if (sys_cnt == 3)
      i_sys_clk <= ~i_sys_clk;
    if (posc_cnt == 5)
      i_posc_clk <= ~i_posc_clk;
  end

  rco_top i_rco_top (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_byteenable(i_byteenable), .i_writedata(i_writedata),
    .o_waitrequest(o_waitrequest), .o_readdata(o_readdata),
    .i_posc_clk(i_posc_clk), .i_sys_clk(i_sys_clk),
    .i_sleep(i_sleep), .i_posc_mode(i_posc_mode),
    .i_posc_on(i_posc_on), .o_posc_pwrdn(o_posc_pwrdn),
    .o_refout_pin(o_refout_pin));

  rco_refout_monitor i_rco_refout_monitor (.i_mclk(i_mclk),
    .i_pin(o_refout_pin), .o_hi_len(hi_len), .o_lo_len(lo_len),
    .o_edges(edges));

  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Compares a seen value with the expected one.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One Avalon access; waits for waitrequest low, bounded.
  task bus(input logic wr, input logic [3:0] a, input rco_word_t d);
    int k;
    k = 0;
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= ~wr;
    do
    begin
      @(posedge i_mclk);
      k++;
    end while (o_waitrequest !== 1'b0 && k < 50);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    @(posedge i_mclk);
    if (k >= 50)
    begin
      failures++;
      end_sim();
    end
  endtask : bus

  // Checks that the pin stays low for a number of cycles.
  task hold_low(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge i_mclk);
      seen = seen | (o_refout_pin !== 1'b0);
    end
    check(seen, 0);
  endtask : hold_low

  // Waits for four pin edges, then checks both level lengths.
  task measure(input int half);
    int k;
    logic [31:0] e0;
    k = 0;
    e0 = edges;
    while (edges - e0 < 4 && k < 6 * half + 200)
    begin
      @(posedge i_mclk);
      k++;
    end
    if (edges - e0 < 4)
    begin
      failures++;
      end_sim();
    end
    else
    begin
      check(hi_len, half);
      check(lo_len, half);
    end
  endtask : measure

  // Restarts the output with a new setting and times it awake.
  task run_case(input logic rsl, input logic src, input int n);
    bus(1'b1, 4'h0, 32'h0000_0000);
    bus(1'b1, 4'h0, {16'h0000, 1'b1, 1'b0, rsl, src, n[3:0], 8'h00});
    measure((src ? 6 : 4) << n);
  endtask : run_case

  // Enters Sleep with a setting and checks power-down and the pin.
  task sleep_case(input logic rsl, input logic src, input logic keep,
                  input logic mode, input logic runs);
    i_posc_mode <= mode;
    bus(1'b1, 4'h4, {31'h0, keep});
    bus(1'b0, 4'h4, 32'h0000_0000);
    check(rd[0], keep);
    run_case(rsl, src, 1);
    i_sleep <= 1'b1;
    repeat (5) @(posedge i_mclk);
    check(o_posc_pwrdn, !(mode | keep));
    if (runs)
      measure(src ? 12 : 8);
    else
      hold_low(100);
    i_sleep <= 1'b0;
    @(posedge i_mclk);
  endtask : sleep_case

  // Main sequence.
  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    check(o_refout_pin, 0);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(rd, 32'h0000_BF00);
    i_byteenable <= 4'h1;
    bus(1'b1, 4'h0, 32'h0000_0000);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(rd, 32'h0000_BF00);
    i_byteenable <= 4'hF;
    bus(1'b1, 4'h8, 32'hFFFF_FFFF);
    bus(1'b0, 4'h8, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'h0000_0000);
    repeat (4) @(posedge i_mclk);
    hold_low(100);
    for (int n = 0; n < 9; n++)
      run_case(1'b0, 1'b0, n);
    for (int n = 0; n < 3; n++)
      run_case(1'b0, 1'b1, n);
    sleep_case(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    sleep_case(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    sleep_case(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    sleep_case(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    sleep_case(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    i_posc_on <= 1'b0;
    sleep_case(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    i_posc_on <= 1'b1;
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    check(o_refout_pin, 0);
    bus(1'b0, 4'h0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    end_sim();
  end
endmodule : testbench
